// ==== core/spc_core.sv ====
/*
 * Serial port control of a delta-sigma converter: select handling,
 * continuous read, master or slave clocking, data line turnaround,
 * result overwrite timing, and an AHB-Lite register slave.
 * Assumes pins arrive asynchronously and clk_sys is the master clock.
 */
`include "spc_defs.svh"

module spc_core
	import spc_pkg::*;
#(
	parameter int unsigned CONV_CYCLES  = 32'(64'(`SPC_CONV_PS) / 64'(`SPC_CLK_PS)),
	parameter int unsigned STALL_CYCLES = `SPC_STALL_PER * CONV_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        mode_pin,
	input  wire logic        sel_n_pin,
	input  wire logic        sclk_in,
	output logic             sclk_out,
	output logic             sclk_oe,
	input  wire logic        sdio_in,
	output logic             sdio_out,
	output logic             sdio_oe,
	output logic             serial_out_line,
	output logic             serial_out_line_oe,
	output logic             result_ready_n
);

	localparam int unsigned TURN_WAIT = `SPC_TURN_MIN - `SPC_SYNC_LAT;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [3:0] pin_raw;
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;

	assign pin_raw = {mode_pin, sel_n_pin, sclk_in, sdio_in};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
				end else begin
					sync1_ff[gi] <= pin_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate

	logic is_master;
	logic sel_n;
	logic sclk_s;
	logic sdio_s;

	assign is_master = sync2_ff[3];
	assign sel_n     = sync2_ff[2];
	assign sclk_s    = sync2_ff[1];
	assign sdio_s    = sync2_ff[0];

	// ****************************************************************
	// registers and state
	// ****************************************************************
	spc_state_t   state_ff;
	spc_bus_req_t req_ff;
	logic [31:0]  hrdata_ff;
	logic         ctrl_sdio_out_ff;
	logic [23:0]  src_ff;
	logic [23:0]  result_ff;
	logic [7:0]   instr_ff;
	logic [7:0]   ishift_ff;
	logic [31:0]  oshift_ff;
	logic [5:0]   bitcnt_ff;
	logic [2:0]   turncnt_ff;
	logic [31:0]  conv_cnt_ff;
	logic [31:0]  stall_ff;
	logic         rdy_n_ff;
	logic         done_ff;
	logic         cr_en_ff;
	logic         cr_act_ff;
	logic         sclk_d_ff;
	logic         div_ff;
	logic         mclk_ff;
	logic         drive_ff;

	// ****************************************************************
	// ahb-lite slave, zero wait states
	// ****************************************************************
	function automatic logic [2:0] reg_sel(input logic [11:0] a);
		case (a)
			`SPC_OFS_CTRL:   reg_sel = 3'h1;
			`SPC_OFS_SRC:    reg_sel = 3'h2;
			`SPC_OFS_STATUS: reg_sel = 3'h3;
			`SPC_OFS_RESULT: reg_sel = 3'h4;
			`SPC_OFS_INSTR:  reg_sel = 3'h5;
			default:         reg_sel = 3'h0;
		endcase
	endfunction

	logic take;
	logic [31:0] rd_mux;
	logic [31:0] status_w;

	assign take     = hsel && hready && htrans[1];
	assign status_w = {27'h0, state_ff != SPC_IDLE, cr_act_ff, cr_en_ff, is_master, ~rdy_n_ff};

	always_comb begin
		case (reg_sel(haddr[11:0]))
			3'h1:    rd_mux = {31'h0, ctrl_sdio_out_ff};
			3'h2:    rd_mux = {8'h00, src_ff};
			3'h3:    rd_mux = status_w;
			3'h4:    rd_mux = {8'h00, result_ff};
			3'h5:    rd_mux = {24'h0, instr_ff};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			req_ff    <= '0;
			hrdata_ff <= 32'h0;
		end else begin
			if (hready) begin
				req_ff <= '{valid: take, write: hwrite, addr: haddr[11:0]};
			end
			if (take && !hwrite) begin
				hrdata_ff <= rd_mux;
			end
		end
	end

	// the reset value makes the bidirectional line the result output
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl_sdio_out_ff <= `SPC_CTRL_RESET;
			src_ff           <= 24'h0;
		end else if (req_ff.valid && req_ff.write) begin
			case (reg_sel(req_ff.addr))
				3'h1:    ctrl_sdio_out_ff <= hwdata[`SPC_CTRL_SDIO_OUT];
				3'h2:    src_ff <= hwdata[23:0];
				default: ;
			endcase
		end
	end

	assign hrdata    = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ****************************************************************
	// conversion timing and result update
	// ****************************************************************
	logic pre_tick;
	logic tick;
	logic reading;
	logic upd;

	assign pre_tick = conv_cnt_ff == CONV_CYCLES - 32'd2;
	assign tick     = conv_cnt_ff == CONV_CYCLES - 32'd1;
	assign reading  = state_ff == SPC_DATA && instr_ff[`SPC_INS_RD];
	assign upd      = tick && !reading;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			conv_cnt_ff <= 32'h0;
		end else begin
			conv_cnt_ff <= tick ? 32'h0 : conv_cnt_ff + 32'd1;
		end
	end

	// unread results are simply replaced
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			result_ff <= 24'h0;
		end else if (upd) begin
			result_ff <= src_ff;
		end
	end

	logic xfer_end;

	// ready goes high one cycle ahead of the update and low after it
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdy_n_ff <= 1'b1;
		end else if (pre_tick) begin
			rdy_n_ff <= 1'b1;
		end else if (upd) begin
			rdy_n_ff <= 1'b0;
		end else if (xfer_end && reading) begin
			rdy_n_ff <= 1'b1;
		end
	end

	// ****************************************************************
	// serial clock: generated in master mode, sampled in slave mode
	// ****************************************************************
	logic run_clk;
	logic rise_ev;
	logic fall_ev;

	assign run_clk = is_master && (state_ff == SPC_INSTR || state_ff == SPC_DATA);

	// toggling every second cycle gives a quarter of the master clock
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			div_ff  <= 1'b0;
			mclk_ff <= 1'b0;
		end else if (run_clk) begin
			div_ff <= ~div_ff;
			if (div_ff) begin
				mclk_ff <= ~mclk_ff;
			end
		end else begin
			div_ff  <= 1'b0;
			mclk_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sclk_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_s;
		end
	end

	// slave edges are ignored while select is high
	always_comb begin
		if (is_master) begin
			rise_ev = run_clk && div_ff && !mclk_ff;
			fall_ev = run_clk && div_ff && mclk_ff;
		end else begin
			rise_ev = !sel_n && sclk_s && !sclk_d_ff;
			fall_ev = !sel_n && !sclk_s && sclk_d_ff;
		end
	end

	// ****************************************************************
	// transfer sequencing
	// ****************************************************************
	logic [5:0] nbits;
	logic       m_start;
	logic       stalled;

	assign nbits    = {1'b0, 2'(instr_ff[`SPC_INS_CNT_HI:`SPC_INS_CNT_LO]) + 2'd0, 3'h0} + 6'd8;
	// select high holds off the ready-time transfer, once per period
	assign m_start  = is_master && !sel_n && !rdy_n_ff && !done_ff;
	assign stalled  = stall_ff >= STALL_CYCLES - 32'd1;
	assign xfer_end = state_ff == SPC_DATA && fall_ev && bitcnt_ff == nbits;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_ff   <= SPC_IDLE;
			ishift_ff  <= 8'h0;
			instr_ff   <= 8'h0;
			bitcnt_ff  <= 6'h0;
			turncnt_ff <= 3'h0;
		end else if (stalled && state_ff != SPC_IDLE) begin
			state_ff <= SPC_IDLE;
		end else begin
			case (state_ff)
				SPC_IDLE: begin
					bitcnt_ff  <= 6'h0;
					turncnt_ff <= 3'h0;
					// stored instruction is reused in continuous read
					if ((m_start && cr_act_ff) || (!is_master && cr_act_ff && upd)) begin
						state_ff <= SPC_TURN;
					end else if (m_start) begin
						state_ff <= SPC_INSTR;
					end else if (!is_master && rise_ev) begin
						ishift_ff <= {ishift_ff[6:0], sdio_s};
						bitcnt_ff <= 6'd1;
						state_ff  <= SPC_INSTR;
					end
				end
				SPC_INSTR: begin
					if (rise_ev) begin
						ishift_ff <= {ishift_ff[6:0], sdio_s};
						bitcnt_ff <= bitcnt_ff + 6'd1;
					end else if (fall_ev && bitcnt_ff == 6'd8) begin
						instr_ff  <= ishift_ff;
						bitcnt_ff <= 6'h0;
						// an all-zero byte is a one-byte write that is discarded
						state_ff  <= ishift_ff[`SPC_INS_RD] ? SPC_TURN : SPC_DATA;
					end
				end
				SPC_TURN: begin
					// line turns after the last instruction fall
					turncnt_ff <= turncnt_ff + 3'd1;
					if (turncnt_ff == 3'(TURN_WAIT - 1)) begin
						state_ff <= SPC_DATA;
					end
				end
				SPC_DATA: begin
					if (rise_ev) begin
						bitcnt_ff <= bitcnt_ff + 6'd1;
					end else if (xfer_end) begin
						state_ff <= SPC_IDLE;
					end
				end
				default: state_ff <= SPC_IDLE;
			endcase
		end
	end

	// counts idle link time inside a transfer; registers are left intact
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			stall_ff <= 32'h0;
		end else if (state_ff == SPC_IDLE || state_ff == SPC_TURN || rise_ev || fall_ev) begin
			stall_ff <= 32'h0;
		end else begin
			stall_ff <= stall_ff + 32'd1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
		end else if (tick) begin
			done_ff <= 1'b0;
		end else if (m_start) begin
			done_ff <= 1'b1;
		end
	end

	// enabled for good by the first high select; entered only by a read with select low
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cr_en_ff  <= 1'b0;
			cr_act_ff <= 1'b0;
		end else begin
			if (sel_n) begin
				cr_en_ff <= 1'b1;
			end
			if (sel_n) begin
				cr_act_ff <= 1'b0;
			end else if (xfer_end && reading && cr_en_ff) begin
				cr_act_ff <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// output shifting and line drive
	// ****************************************************************
	// the select pin has no say in the drive
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			oshift_ff <= 32'h0;
			drive_ff  <= 1'b0;
		end else if (state_ff == SPC_TURN && turncnt_ff == 3'(TURN_WAIT - 1)) begin
			oshift_ff <= {result_ff, 8'h00};
			drive_ff  <= instr_ff[`SPC_INS_RD];
		end else if (state_ff != SPC_DATA || xfer_end) begin
			drive_ff <= 1'b0;
		end else if (fall_ev && drive_ff) begin
			oshift_ff <= {oshift_ff[30:0], 1'b0};
		end
	end

	// one-cycle lag keeps data and enable aligned at the pins
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sdio_out           <= 1'b0;
			sdio_oe            <= 1'b0;
			serial_out_line    <= 1'b0;
			serial_out_line_oe <= 1'b0;
		end else begin
			sdio_out           <= oshift_ff[31];
			sdio_oe            <= drive_ff && ctrl_sdio_out_ff;
			serial_out_line    <= oshift_ff[31];
			serial_out_line_oe <= drive_ff && !ctrl_sdio_out_ff;
		end
	end

	// the clock pin is an output only in master mode
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sclk_out       <= 1'b0;
			sclk_oe        <= 1'b0;
			result_ready_n <= 1'b1;
		end else begin
			sclk_out       <= mclk_ff;
			sclk_oe        <= is_master;
			result_ready_n <= rdy_n_ff;
		end
	end

endmodule

// ==== core/spc_defs.svh ====
/*
 * Constants of the serial port control block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 200 MHz clk_sys that also stands for the converter master clock.
 */
// Functional notes
// - both data outputs float except while bits are actually being shifted out
// - raising select mid-output does not release the driven line
// - master mode: select high delays the ready-time transfer until select falls
// - slave mode: serial clock edges count only while select is low
// - select low after a result read: reuse stored instruction at next ready
// - first select high enables continuous read for good
// - after reset the bidirectional line is the data output pin
// - master, select low: clock runs when ready low; 0xff reads 32 clocks
// - all-zero instruction is a one-byte result write with no effect
// - default result rate about 345 Hz, period 2.9 ms
// - mode high: device is master and drives the serial clock
// - master serial clock is master clock divided by four
// - master mode: at most one instruction per conversion period
// - master, select high: each unread result overwritten, ready pulsed high
// - mode low: slave, external clock, many instructions per period
// - slave: line turns to output six to eight clocks after last fall
// - slave, no transfer: result overwritten, ready pulsed high before update
// - result update suppressed while the result is being read
// - stall over four data periods resets the serial interface only
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define SPC_OFS_CTRL    12'h000
`define SPC_OFS_SRC     12'h004
`define SPC_OFS_STATUS  12'h008
`define SPC_OFS_RESULT  12'h00c
`define SPC_OFS_INSTR   12'h010

`define SPC_CTRL_SDIO_OUT 0
`define SPC_CTRL_RESET    1'b1

// ****************************************************************
// instruction fields and timing
// ****************************************************************
`define SPC_INS_RD      7
`define SPC_INS_CNT_HI  6
`define SPC_INS_CNT_LO  5

`define SPC_CLK_PS      5000
`define SPC_CONV_PS     64'd2900000000
`define SPC_TURN_MIN    6
`define SPC_SYNC_LAT    2
`define SPC_STALL_PER   4

`endif

// ==== core/spc_pkg.sv ====
/*
 * Types of the serial port control block.
 * Assumes spc_defs.svh is included by the design file.
 */
package spc_pkg;

	typedef enum logic [2:0] {
		SPC_IDLE,
		SPC_INSTR,
		SPC_TURN,
		SPC_DATA
	} spc_state_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
	} spc_bus_req_t;

endpackage

// ==== sim/spc_core_chk.sv ====
/*
 * Port checker of spc_core: reset idle state, output enables, serial clock
 * shape and turnaround timing.
 * Assumes it is bound to spc_core and that rst_n is low at time zero.
 */
// ************************************************
// checker
// ************************************************
module spc_core_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic mode_pin,
	input wire logic sclk_in,
	input wire logic sclk_out,
	input wire logic sclk_oe,
	input wire logic sdio_oe,
	input wire logic serial_out_line_oe,
	input wire logic result_ready_n
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// two low cycles after the high pair give the divide by four
	sequence sclk_tail;
		sclk_out ##1 !sclk_out ##1 !sclk_out;
	endsequence

	reset_idle_a: assert property (disable iff (1'b0) !rst_n |=> !sdio_oe && !serial_out_line_oe && result_ready_n)
		else $error("outputs not idle after reset");
	out_excl_a: assert property (!(sdio_oe && serial_out_line_oe))
		else $error("both data outputs driven");
	slave_clk_a: assert property (!mode_pin [*5] |-> !sclk_oe && !sclk_out)
		else $error("serial clock driven in slave mode");
	master_clk_a: assert property (mode_pin [*5] |-> sclk_oe)
		else $error("serial clock not driven in master mode");
	sclk_div_a: assert property ($rose(sclk_out) |=> sclk_tail)
		else $error("serial clock period not four");
	sclk_ready_a: assert property ($rose(sclk_out) |-> !result_ready_n)
		else $error("serial clock runs while not ready");
	turn_delay_a: assert property ($rose(sdio_oe) && !sclk_oe |-> !sclk_in && !$past(sclk_in, 5))
		else $error("data line turned too early");
	// the forced-high pulse lasts one cycle; the low level after an update must then stand
	ready_high_a: assert property ($fell(result_ready_n) |-> $past(result_ready_n) ##1 !result_ready_n [*2])
		else $error("ready not held low after update");
endmodule

bind spc_core spc_core_chk u_chk (.clk_sys, .rst_n, .mode_pin, .sclk_in, .sclk_out, .sclk_oe, .sdio_oe,
	.serial_out_line_oe, .result_ready_n);

// ==== sim/spc_host_model.sv ====
/*
 * Host controller model: drives select-free serial frames on the clock
 * and data line, or holds the data line at a level.
 * Assumes the bench resolves the data line and owns the select pin.
 */
module spc_host_model (
	input  wire logic clk_sys,
	input  wire logic line,
	output logic      sclk,
	output logic      d,
	output logic      oe
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sclk = 1'b0;
		d = 1'b0;
		oe = 1'b0;
	end

	// five master clocks a half period keeps the rate at clk/10
	task automatic tick(input logic b);
		sclk <= b;
		repeat (5) @(posedge clk_sys);
	endtask

	task automatic hold(input logic v);
		oe <= 1'b1;
		d <= v;
	endtask

	task automatic xfer(input logic [7:0] ins, input int nb, input logic skip, output logic [31:0] q);
		q = '0;
		if (!skip) begin
			oe <= 1'b1;
			for (int i = 7; i >= 0; i--) begin
				d <= ins[i];
				tick(1'b0);
				tick(1'b1);
			end
		end
		// release at the last fall, before the device turns the line
		oe <= 1'b0;
		tick(1'b0);
		repeat (10) @(posedge clk_sys);
		for (int j = 0; j < nb * 8; j++) begin
			tick(1'b1);
			q = {q[30:0], line};
			tick(1'b0);
		end
	endtask
endmodule

// ==== sim/test_adc_serial_port_control.sv ====
/*
 * Self-checking bench of spc_core in slave and master mode.
 * Assumes a short conversion period set through the parameters.
 */
`include "spc_defs.svh"

module test_adc_serial_port_control;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        mode_pin = 1'b0;
	logic        sel_n_pin = 1'b0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] q;
	logic        last = 1'b0;
	logic        o;
	wire  [31:0] hrdata;
	wire         hready, hreadyout, hresp, sclk_out, sclk_oe, sdio_out, sdio_oe;
	wire         sol, sol_oe, rdy_n, h_sclk, h_d, h_oe, line;
	int          miscompares = 0;
	int          num_checks = 0;
	int          oe_cyc = 0;
	int          sol_cyc = 0;
	int          c;

	assign hready = hreadyout;
	// undriven line flips each cycle so a stale value never passes
	assign line = sdio_oe ? sdio_out : h_oe ? h_d : ~last;
	always @(posedge clk_sys) last <= line;
	always @(posedge clk_sys) if (sdio_oe === 1'b1) oe_cyc <= oe_cyc + 1;
	always @(posedge clk_sys) if (sol_oe === 1'b1) sol_cyc <= sol_cyc + 1;

	initial forever #2.5 clk_sys = ~clk_sys;

	spc_core #(.CONV_CYCLES(2000), .STALL_CYCLES(500)) DUT (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .mode_pin, .sel_n_pin, .sclk_in(h_sclk), .sclk_out,
		.sclk_oe, .sdio_in(line), .sdio_out, .sdio_oe, .serial_out_line(sol), .serial_out_line_oe(sol_oe),
		.result_ready_n(rdy_n));
	spc_host_model host (.clk_sys, .line, .sclk(h_sclk), .d(h_d), .oe(h_oe));

	// ************************************************
	// shared tasks
	// ************************************************
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic tmo;
		chk(32'h0, 32'h1);
		results();
	endtask

	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 100);
		if (n >= 50) tmo();
		q = hrdata;
	endtask

	task automatic wt(input logic v);
		int n;
		n = 0;
		while (rdy_n !== v && n < 5000) begin
			@(negedge clk_sys);
			n++;
		end
		if (rdy_n !== v) tmo();
		@(posedge clk_sys);
	endtask

	task automatic cnt(input int n);
		logic p;
		c = 0;
		o = 1'b0;
		p = 1'b1;
		repeat (n) begin
			@(negedge clk_sys);
			if (sclk_out === 1'b1 && p !== 1'b1) c++;
			if (sdio_oe === 1'b1) o = 1'b1;
			p = sclk_out;
		end
		@(posedge clk_sys);
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_reset;
		chk({30'h0, sdio_oe, sol_oe}, 32'h0);
		ahb(1'b0, `SPC_OFS_CTRL, 32'h0);
		chk(q, 32'h1);
		ahb(1'b0, `SPC_OFS_STATUS, 32'h0);
		chk({30'h0, q[2:1]}, 32'h0);
		ahb(1'b0, 12'h100, 32'h0);
		chk(q, 32'h0);
		chk({30'h0, hresp, hreadyout}, 32'h1);
		$display("test reset done");
	endtask

	task automatic t_slave_read;
		ahb(1'b1, `SPC_OFS_SRC, 32'ha5c3e1);
		wt(1'b1);
		wt(1'b0);
		host.xfer(8'hc0, 3, 1'b0, q);
		chk(q, 32'ha5c3e1);
		ahb(1'b0, `SPC_OFS_RESULT, 32'h0);
		chk(q, 32'ha5c3e1);
		chk({31'h0, sdio_oe}, 32'h0);
		$display("test slave read done");
	endtask

	task automatic t_sel_gate;
		int b;
		sel_n_pin <= 1'b1;
		@(posedge clk_sys);
		b = oe_cyc;
		host.xfer(8'hc0, 3, 1'b0, q);
		chk(oe_cyc - b, 32'h0);
		ahb(1'b0, `SPC_OFS_STATUS, 32'h0);
		chk({31'h0, q[2]}, 32'h1);
		$display("test select gate done");
	endtask

	task automatic t_cont_read;
		sel_n_pin <= 1'b0;
		ahb(1'b1, `SPC_OFS_SRC, 32'h3c5a96);
		wt(1'b1);
		wt(1'b0);
		host.xfer(8'hc0, 3, 1'b0, q);
		chk(q, 32'h3c5a96);
		ahb(1'b1, `SPC_OFS_SRC, 32'h1e2d4b);
		wt(1'b1);
		wt(1'b0);
		repeat (12) @(posedge clk_sys);
		host.xfer(8'h00, 3, 1'b1, q);
		chk(q, 32'h1e2d4b);
		sel_n_pin <= 1'b1;
		$display("test continuous read done");
	endtask

	task automatic t_overwrite;
		ahb(1'b1, `SPC_OFS_SRC, 32'h0f1e2d);
		wt(1'b1);
		wt(1'b0);
		ahb(1'b1, `SPC_OFS_SRC, 32'h4b5a69);
		wt(1'b1);
		wt(1'b0);
		ahb(1'b0, `SPC_OFS_RESULT, 32'h0);
		chk(q, 32'h4b5a69);
		$display("test overwrite done");
	endtask

	task automatic t_alt_out;
		int b;
		int s;
		sel_n_pin <= 1'b0;
		ahb(1'b1, `SPC_OFS_CTRL, 32'h0);
		b = oe_cyc;
		s = sol_cyc;
		host.xfer(8'hc0, 3, 1'b0, q);
		chk(oe_cyc - b, 32'h0);
		chk({31'h0, sol_cyc > s}, 32'h1);
		sel_n_pin <= 1'b1;
		ahb(1'b1, `SPC_OFS_CTRL, 32'h1);
		ahb(1'b0, `SPC_OFS_CTRL, 32'h0);
		chk(q, 32'h1);
		$display("test alternate output done");
	endtask

	task automatic t_master;
		mode_pin <= 1'b1;
		host.hold(1'b0);
		wt(1'b1);
		wt(1'b0);
		cnt(200);
		chk(c, 32'h0);
		sel_n_pin <= 1'b0;
		cnt(400);
		chk(c, 32'h10);
		chk({31'h0, o}, 32'h0);
		cnt(800);
		chk(c, 32'h0);
		ahb(1'b0, `SPC_OFS_INSTR, 32'h0);
		chk(q, 32'h0);
		ahb(1'b0, `SPC_OFS_STATUS, 32'h0);
		chk({31'h0, q[1]}, 32'h1);
		host.hold(1'b1);
		wt(1'b1);
		wt(1'b0);
		cnt(400);
		chk(c, 32'h28);
		chk({31'h0, o}, 32'h1);
		sel_n_pin <= 1'b1;
		$display("test master done");
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_slave_read();
		t_sel_gate();
		t_cont_read();
		t_overwrite();
		t_alt_out();
		t_master();
		results();
	end
endmodule
